/* rtl/hmc_pkg.sv */
/*
 * hmc_pkg: constants for the harvester charge controller.
 * assumes a 50 MHz mclk; register map sits on a 32-bit avalon-mm slave.
 */
package hmc_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam logic [5:0] A_CTRL = 6'h00;
   localparam logic [5:0] A_TRACK_CFG = 6'h04;
   localparam logic [5:0] A_IRQ_EN = 6'h08;
   localparam logic [5:0] A_IRQ_FLAG = 6'h0c;
   localparam logic [5:0] A_MON_CFG = 6'h10;
   localparam logic [5:0] A_MON_DATA = 6'h14;
   localparam logic [5:0] A_STATUS = 6'h18;
   localparam logic [5:0] A_TARGET = 6'h1c;
   localparam int CTRL_UPDATE = 0;
   localparam int CTRL_KEEP_ALIVE = 1;
   localparam int CFG_RATIO_LSB = 0;
   localparam int CFG_TIMING_LSB = 4;
   localparam int IRQ_READY = 0;
   localparam int IRQ_MON_DONE = 1;
   localparam logic [1:0] IRQ_EN_RST = 2'h1;
   localparam logic [6:0] TRACK_CFG_RST = 7'h77;
   localparam logic [3:0] RATIO_MAX = 4'h9;
   localparam int unsigned THERM_PERIOD_S = 8;
   localparam logic [11:0] VMPP_MIN_MV = 12'h078;
   localparam logic [11:0] VMPP_MAX_MV = 12'h5dc;
   localparam logic [31:0] SEC_CYCLES = 32'(CLK_HZ);
   typedef enum logic [2:0] {HMC_RESET, HMC_SENSE_SRC, HMC_SENSE_STO, HMC_SUPPLY,
                             HMC_SLEEP} hmc_state_t;
   typedef enum logic [1:0] {HMC_T_RUN, HMC_T_SETTLE, HMC_T_SAMPLE} hmc_trk_t;
   typedef enum logic [1:0] {HMC_M_IDLE, HMC_M_MEASURE, HMC_M_WAIT} hmc_mon_t;
   // open-circuit settle time and sampling period in ms per timing code
   function automatic logic [31:0] settle_ms(input logic [2:0] c);
      case (c)
         3'h0: settle_ms = 32'd2;
         3'h1: settle_ms = 32'd256;
         3'h2: settle_ms = 32'd64;
         3'h3: settle_ms = 32'd8;
         3'h4: settle_ms = 32'd4;
         3'h5: settle_ms = 32'd2;
         3'h6: settle_ms = 32'd4;
         default: settle_ms = 32'd2;
      endcase
   endfunction : settle_ms
   function automatic logic [31:0] period_ms(input logic [2:0] c);
      case (c)
         3'h0: period_ms = 32'd64;
         3'h1: period_ms = 32'd16384;
         3'h2: period_ms = 32'd4096;
         3'h3: period_ms = 32'd1024;
         3'h4: period_ms = 32'd256;
         3'h5: period_ms = 32'd128;
         3'h6: period_ms = 32'd512;
         default: period_ms = 32'd256;
      endcase
   endfunction : period_ms
   // ratio code to percent; code 0 (impedance matching) treated as 100
   function automatic logic [6:0] ratio_pct(input logic [3:0] c);
      case (c)
         4'h1: ratio_pct = 7'd90;
         4'h2: ratio_pct = 7'd65;
         4'h3: ratio_pct = 7'd60;
         4'h4: ratio_pct = 7'd85;
         4'h5: ratio_pct = 7'd75;
         4'h6: ratio_pct = 7'd70;
         4'h7: ratio_pct = 7'd80;
         4'h8: ratio_pct = 7'd35;
         4'h9: ratio_pct = 7'd50;
         default: ratio_pct = 7'd100;
      endcase
   endfunction : ratio_pct
endpackage : hmc_pkg

/* rtl/hmc_timer.sv */
/*
 * hmc_timer: free-running period counter giving a one-cycle tick.
 * assumes a period of at least one cycle.
 */
`timescale 1ns/1ps
module hmc_timer
   import hmc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [31:0] period,
   output logic tick
);
   logic [31:0] cnt_q, cnt_d;
   always_comb begin
      tick = (cnt_q + 32'd1 >= period);
      cnt_d = tick ? 32'd0 : cnt_q + 32'd1;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 32'd0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : hmc_timer

/* rtl/hmc_charge_ctrl.sv */
/*
 * hmc_charge_ctrl: tracking, output routing, thermal pacing and power monitor.
 * assumes comparator and adc results synchronous to mclk; host on avalon-mm.
 */
// Contract
// - each period stop extraction, settle, sample voltage
// - open source isolation switch during evaluation
// - tracking active only in supply and sense states
// - nine ratios, targets 0.12 to 1.50 V
// - ratio from register or ratio pins
// - timing pair from register or timing pins
// - open battery switch at overcharge threshold
// - no keep-alive: low rail steers to core switch
// - keep-alive: feed rail via battery-to-core, never core
// - stop battery feed below overdischarge threshold
// - thermal check periodic, every 8 s
// - monitor has pulse-counter and power-meter modes
// - pulse mode counts pulses during measure window
// - meter mode accumulates energy during measure window
// - wait phase equals measure window
// - done raises interrupt only when enabled
// - done flag set when result stored
// - charge inhibit stops charging
// - only interface-ready enabled after start-up
`timescale 1ns/1ps
module hmc_charge_ctrl
   import hmc_pkg::*;
#(
   parameter logic [31:0] THERM_CYCLES = 32'(THERM_PERIOD_S) * SEC_CYCLES,
   parameter logic [31:0] MS_TICK = 32'(MS_CYCLES)
)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [2:0] ratio_select_pins,
   input wire logic [1:0] timing_select_pins,
   input wire logic charge_inhibit,
   input wire logic rail_ready,
   input wire logic [2:0] state_req,
   input wire logic [11:0] harvester_node_mv,
   input wire logic vint_low,
   input wire logic vint_above_hyst,
   input wire logic at_overcharge_threshold,
   input wire logic below_overdischarge_threshold,
   input wire logic conv_pulse,
   input wire logic [15:0] energy_quantum,
   output logic source_isolation_switch,
   output logic extract_enable,
   output logic sample_strobe,
   output logic [11:0] target_mv,
   output logic core_rail_switch,
   output logic battery_switch,
   output logic battery_to_core_switch,
   output logic thermal_sample,
   output logic irq
);
   hmc_state_t st_q, st_d;
   hmc_trk_t trk_q, trk_d;
   hmc_mon_t mon_q, mon_d;
   logic [6:0] cfg_q, cfg_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic [1:0] irq_en_q, irq_en_d;
   logic [1:0] irq_flag_q, irq_flag_d;
   logic [16:0] mon_cfg_q, mon_cfg_d;
   logic [31:0] mon_data_q, mon_data_d;
   logic [31:0] acc_q, acc_d;
   logic [31:0] cnt_q, cnt_d;
   logic [31:0] ms_q, ms_d;
   logic [11:0] voc_q, voc_d;
   logic [11:0] tgt_q, tgt_d;
   logic core_mode_q, core_mode_d;
   logic irq_q, irq_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic [3:0] ratio;
   logic [2:0] timing;
   logic track_on, ms_tick, bus_req, therm_tick;
   logic [18:0] prod;
   logic [11:0] scaled;
   logic ready_evt, done_evt;

   hmc_timer u_therm (
      .mclk(mclk),
      .nrst(nrst),
      .period(THERM_CYCLES),
      .tick(therm_tick)
   );
   assign thermal_sample = therm_tick;

   // after an update, register values override the pins
   always_comb begin
      ratio = ctrl_q[CTRL_UPDATE] ? cfg_q[3:0] : {1'b0, ratio_select_pins};
      if (ratio > RATIO_MAX) ratio = RATIO_MAX;
      timing = ctrl_q[CTRL_UPDATE] ? cfg_q[6:4] : {1'b1, timing_select_pins};
      track_on = (st_q == HMC_SUPPLY) || (st_q == HMC_SENSE_SRC)
                 || (st_q == HMC_SENSE_STO);
      prod = 19'(voc_q) * 19'(ratio_pct(ratio));
      scaled = 12'(prod / 19'd100);
      if (scaled < VMPP_MIN_MV) scaled = VMPP_MIN_MV;
      if (scaled > VMPP_MAX_MV) scaled = VMPP_MAX_MV;
   end

   always_comb begin
      ms_tick = (ms_q + 32'd1 >= MS_TICK);
      ms_d = ms_tick ? 32'd0 : ms_q + 32'd1;
   end

   // power state follows the supervisor request once the rail is up
   always_comb begin
      st_d = st_q;
      case (st_q)
         HMC_RESET: if (rail_ready) st_d = HMC_SENSE_SRC;
         default: begin
            if (!rail_ready) st_d = HMC_RESET;
            else if (state_req <= 3'd4) st_d = hmc_state_t'(state_req);
         end
      endcase
   end

   // tracker: run, settle open-circuit, sample
   always_comb begin
      trk_d = trk_q;
      cnt_d = cnt_q;
      voc_d = voc_q;
      tgt_d = tgt_q;
      sample_strobe = 1'b0;
      case (trk_q)
         HMC_T_RUN: begin
            if (!track_on) begin
               cnt_d = 32'd0;
            end else if (ms_tick) begin
               cnt_d = cnt_q + 32'd1;
               // settle time counts inside the sampling period
               if (cnt_q + 32'd1 >= period_ms(timing) - settle_ms(timing)) begin
                  cnt_d = 32'd0;
                  trk_d = HMC_T_SETTLE;
               end
            end
         end
         HMC_T_SETTLE: begin
            if (!track_on) begin
               trk_d = HMC_T_RUN;
               cnt_d = 32'd0;
            end else if (ms_tick) begin
               cnt_d = cnt_q + 32'd1;
               if (cnt_q + 32'd1 >= settle_ms(timing)) trk_d = HMC_T_SAMPLE;
            end
         end
         HMC_T_SAMPLE: begin
            sample_strobe = 1'b1;
            voc_d = harvester_node_mv;
            trk_d = HMC_T_RUN;
            cnt_d = 32'd0;
         end
         default: trk_d = HMC_T_RUN;
      endcase
      if (trk_q == HMC_T_RUN) tgt_d = scaled;
   end

   always_comb begin
      source_isolation_switch = track_on && (trk_q == HMC_T_RUN);
      extract_enable = track_on && (trk_q == HMC_T_RUN);
      target_mv = tgt_q;
   end

   // output routing
   always_comb begin
      core_mode_d = core_mode_q;
      if (ctrl_q[CTRL_KEEP_ALIVE]) core_mode_d = 1'b0;
      else if (vint_low) core_mode_d = 1'b1;
      else if (vint_above_hyst) core_mode_d = 1'b0;
      core_rail_switch = core_mode_q && !ctrl_q[CTRL_KEEP_ALIVE];
      battery_switch = !core_mode_q && !at_overcharge_threshold
                       && !charge_inhibit && st_q != HMC_RESET;
      battery_to_core_switch = ctrl_q[CTRL_KEEP_ALIVE] && vint_low
                               && !below_overdischarge_threshold;
   end

   // monitor: mon_cfg[15:0] window in ms, [16] meter mode; window 0 keeps it idle
   // last_ms marks the final ms tick of a measure or wait phase
   logic [15:0] mcnt_q, mcnt_d;
   logic last_ms;
   always_comb begin
      last_ms = ms_tick && (mcnt_q + 16'd1 >= mon_cfg_q[15:0]);
      mcnt_d = mcnt_q;
      if (mon_q == HMC_M_IDLE) mcnt_d = 16'h0;
      else if (ms_tick) mcnt_d = last_ms ? 16'h0 : mcnt_q + 16'd1;
   end

   // phases start on an ms tick so measure and wait spans match in cycles
   always_comb begin
      mon_d = mon_q;
      acc_d = acc_q;
      mon_data_d = mon_data_q;
      done_evt = 1'b0;
      case (mon_q)
         HMC_M_IDLE: begin
            if (mon_cfg_q[15:0] != 16'h0 && ms_tick) begin
               mon_d = HMC_M_MEASURE;
               acc_d = 32'd0;
            end
         end
         HMC_M_MEASURE: begin
            if (mon_cfg_q[16]) acc_d = acc_q + 32'(energy_quantum);
            else if (conv_pulse) acc_d = acc_q + 32'd1;
            if (last_ms) mon_d = HMC_M_WAIT;
         end
         HMC_M_WAIT: begin
            if (last_ms) begin
               mon_data_d = acc_q;
               done_evt = 1'b1;
               mon_d = HMC_M_MEASURE;
               acc_d = 32'd0;
            end
         end
         default: mon_d = HMC_M_IDLE;
      endcase
      if (mon_cfg_q[15:0] == 16'h0) mon_d = HMC_M_IDLE;
   end

   // bus: one wait cycle, answer registered
   always_comb begin
      bus_req = (avs_read || avs_write) && !ack_q;
      ack_d = bus_req;
      avs_waitrequest = (avs_read || avs_write) && !ack_q;
      avs_readdata = rdata_q;
      ready_evt = (st_q == HMC_RESET) && rail_ready;
      cfg_d = cfg_q;
      ctrl_d = ctrl_q;
      irq_en_d = irq_en_q;
      mon_cfg_d = mon_cfg_q;
      irq_flag_d = irq_flag_q;
      rdata_d = rdata_q;
      // a write lands at the edge where waitrequest reads low
      if (ack_q && avs_write && avs_byteenable[0]) begin
         case (avs_address)
            A_CTRL: ctrl_d = avs_writedata[1:0];
            A_TRACK_CFG: cfg_d = avs_writedata[6:0];
            A_IRQ_EN: irq_en_d = avs_writedata[1:0];
            A_IRQ_FLAG: irq_flag_d = irq_flag_q & ~avs_writedata[1:0];
            A_MON_CFG: mon_cfg_d = avs_writedata[16:0];
            default: ;
         endcase
      end
      if (bus_req && avs_read) begin
         case (avs_address)
            A_CTRL: rdata_d = {30'h0, ctrl_q};
            A_TRACK_CFG: rdata_d = {25'h0, cfg_q};
            A_IRQ_EN: rdata_d = {30'h0, irq_en_q};
            A_IRQ_FLAG: rdata_d = {30'h0, irq_flag_q};
            A_MON_CFG: rdata_d = {15'h0, mon_cfg_q};
            A_MON_DATA: rdata_d = mon_data_q;
            A_STATUS: rdata_d = {26'h0, trk_q, core_mode_q, st_q};
            A_TARGET: rdata_d = {20'h0, tgt_q};
            default: rdata_d = 32'h0;
         endcase
      end
      if (ready_evt) irq_flag_d[IRQ_READY] = 1'b1;
      if (done_evt) irq_flag_d[IRQ_MON_DONE] = 1'b1;
      irq_d = |(irq_flag_d & irq_en_q);
   end
   assign irq = irq_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ms_q <= 32'h0;
      end else begin
         ms_q <= ms_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= HMC_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trk_q <= HMC_T_RUN;
         cnt_q <= 32'h0;
         voc_q <= 12'h0;
         tgt_q <= 12'h0;
      end else begin
         trk_q <= trk_d;
         cnt_q <= cnt_d;
         voc_q <= voc_d;
         tgt_q <= tgt_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         core_mode_q <= 1'b0;
      end else begin
         core_mode_q <= core_mode_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mcnt_q <= 16'h0;
      end else begin
         mcnt_q <= mcnt_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mon_q <= HMC_M_IDLE;
         acc_q <= 32'h0;
         mon_data_q <= 32'h0;
      end else begin
         mon_q <= mon_d;
         acc_q <= acc_d;
         mon_data_q <= mon_data_d;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= TRACK_CFG_RST;
         ctrl_q <= 2'h0;
         irq_en_q <= IRQ_EN_RST;
         irq_flag_q <= 2'h0;
         mon_cfg_q <= 17'h0;
         irq_q <= 1'b0;
         rdata_q <= 32'h0;
         ack_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         ctrl_q <= ctrl_d;
         irq_en_q <= irq_en_d;
         irq_flag_q <= irq_flag_d;
         mon_cfg_q <= mon_cfg_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end
endmodule : hmc_charge_ctrl

/* bench/hmc_charge_ctrl_sva.sv */
/* hmc_charge_ctrl_sva: port-level checks of the charge controller.
 * assumes a bind into hmc_charge_ctrl with the same count parameters. */
`timescale 1ns/1ps
module hmc_charge_ctrl_sva #(
   parameter logic [31:0] THERM_CYCLES = 32'd100,
   parameter logic [31:0] MS_TICK = 32'd10
)(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [2:0] state_req,
   input wire logic charge_inhibit,
   input wire logic at_overcharge_threshold,
   input wire logic below_overdischarge_threshold,
   input wire logic source_isolation_switch,
   input wire logic extract_enable,
   input wire logic sample_strobe,
   input wire logic core_rail_switch,
   input wire logic battery_switch,
   input wire logic battery_to_core_switch,
   input wire logic thermal_sample,
   input wire logic irq
);
   logic [31:0] open_q;
   logic [31:0] gap_q;
   logic seen_q;
   // cycles the source has been isolated, and cycles since the last thermal pulse
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         open_q <= 32'h0;
         gap_q <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         open_q <= source_isolation_switch ? 32'h0 : open_q + 32'h1;
         gap_q <= thermal_sample ? 32'h0 : gap_q + 32'h1;
         seen_q <= seen_q | thermal_sample;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_ovch_batt_off: assert property (at_overcharge_threshold |-> !battery_switch)
      else $error("battery switch on at overcharge");
   a_inhibit_batt_off: assert property (charge_inhibit |-> !battery_switch)
      else $error("battery switch on while inhibited");
   a_ovdis_no_feed: assert property (below_overdischarge_threshold |-> !battery_to_core_switch)
      else $error("battery feeds rail below overdischarge");
   a_feed_no_core: assert property (battery_to_core_switch |-> !core_rail_switch)
      else $error("core switch on during battery feed");
   a_core_not_batt: assert property (core_rail_switch |-> !battery_switch)
      else $error("core and battery switch both on");
   a_iso_at_sample: assert property (sample_strobe |-> !source_isolation_switch && !extract_enable)
      else $error("source loaded while sampled");
   a_settle_before: assert property (sample_strobe |-> open_q >= MS_TICK)
      else $error("sample taken before settling");
   a_idle_no_track: assert property ((state_req == 3'h4) [*8] |-> !sample_strobe)
      else $error("tracking active in sleep");
   a_therm_period: assert property (thermal_sample && seen_q |-> gap_q == THERM_CYCLES - 32'h1)
      else $error("thermal pulse spacing wrong");
   c_sample: cover property (sample_strobe);
   c_core: cover property (core_rail_switch);
   c_irq: cover property ($rose(irq));
   c_therm: cover property (thermal_sample && seen_q);
endmodule : hmc_charge_ctrl_sva

/* bench/hmc_pv_model.sv */
/* hmc_pv_model: harvester and battery as the controller sees them.
 * assumes mclk from the bench; voltages set by the bench. */
`timescale 1ns/1ps
module hmc_pv_model #(
   parameter int OVCH_MV = 4200,
   parameter int OVDIS_MV = 3000
)(
   input wire logic mclk,
   input wire logic [11:0] voc_mv,
   input wire logic [12:0] batt_mv,
   output logic [11:0] harvester_node_mv,
   output logic conv_pulse,
   output logic [15:0] energy_quantum,
   output logic at_overcharge_threshold,
   output logic below_overdischarge_threshold
);
   logic [2:0] ph_q = 3'h0;
   // one converter pulse every fifth cycle, so any 20-cycle window holds four
   always @(posedge mclk) ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
   assign conv_pulse = (ph_q == 3'h0);
   assign energy_quantum = conv_pulse ? 16'h0003 : 16'h0000;
   assign harvester_node_mv = voc_mv;
   assign at_overcharge_threshold = (batt_mv >= 13'(OVCH_MV));
   assign below_overdischarge_threshold = (batt_mv < 13'(OVDIS_MV));
endmodule : hmc_pv_model

/* bench/tb_harvester_mppt_charge_control.sv */
/* tb_harvester_mppt_charge_control: bus-level tests of the charge controller.
 * assumes counts shortened to a 100-cycle thermal period and 10-cycle ms. */
`timescale 1ns/1ps
module tb_harvester_mppt_charge_control
   import hmc_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] ratio_pins = 3'h2;
   logic [1:0] timing_pins = 2'h0;
   logic [2:0] state_req = 3'h1;
   logic charge_inhibit = 1'b0, rail_ready = 1'b0, vint_low = 1'b0, vint_above_hyst = 1'b0;
   logic [11:0] voc_mv = 12'h3e8;
   logic [12:0] batt_mv = 13'he74;
   logic [11:0] hv_mv, target_mv;
   logic [15:0] eq;
   logic cp, ovch, ovdis, iso, ext, strobe, core_sw, batt_sw, b2c_sw, therm, irq;
   logic [31:0] q;
   int n_mismatch = 0, cmp_count = 0, n_therm = 0, n_strobe = 0, k;
   longint t0;
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      n_therm <= n_therm + int'(therm === 1'b1);
      n_strobe <= n_strobe + int'(strobe === 1'b1);
   end
   hmc_pv_model u_pv (.mclk(mclk), .voc_mv(voc_mv), .batt_mv(batt_mv), .harvester_node_mv(hv_mv),
      .conv_pulse(cp), .energy_quantum(eq), .at_overcharge_threshold(ovch),
      .below_overdischarge_threshold(ovdis));
   hmc_charge_ctrl #(.THERM_CYCLES(32'd100), .MS_TICK(32'd10)) uut (.mclk(mclk), .nrst(nrst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ratio_select_pins(ratio_pins), .timing_select_pins(timing_pins),
      .charge_inhibit(charge_inhibit), .rail_ready(rail_ready), .state_req(state_req),
      .harvester_node_mv(hv_mv), .vint_low(vint_low), .vint_above_hyst(vint_above_hyst),
      .at_overcharge_threshold(ovch), .below_overdischarge_threshold(ovdis),
      .conv_pulse(cp), .energy_quantum(eq), .source_isolation_switch(iso),
      .extract_enable(ext), .sample_strobe(strobe), .target_mv(target_mv),
      .core_rail_switch(core_sw), .battery_switch(batt_sw), .battery_to_core_switch(b2c_sw),
      .thermal_sample(therm), .irq(irq));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk("waitrequest", 0, 32'(n >= 20));
      @(posedge mclk);
   endtask : bus
   task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rdc
   task automatic wfor(input logic w, input int lim);
      int n;
      n = 0;
      repeat (2) @(posedge mclk);
      while ((w ? irq : strobe) !== 1'b1 && n < lim) begin
         @(posedge mclk);
         n++;
      end
      chk(w ? "irq wait" : "strobe wait", 0, 32'(n >= lim));
   endtask : wfor
   task automatic rt(input logic [2:0] v, input logic [12:0] b, input logic [2:0] e,
         input logic [2:0] m);
      {vint_low, vint_above_hyst, charge_inhibit} <= v;
      batt_mv <= b;
      repeat (2) @(posedge mclk);
      chk("core,batt,feed", e, {core_sw, batt_sw, b2c_sw} & m);
   endtask : rt
   task automatic mon_next();
      bus(1'b1, A_IRQ_FLAG, 32'h3);
      wfor(1'b1, 500);
   endtask : mon_next
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   initial begin
      #1000000;
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      rail_ready <= 1'b1;
      @(posedge mclk);
      rdc("irq_en", A_IRQ_EN, 32'h1);
      rdc("track_cfg", A_TRACK_CFG, 32'h77);
      rdc("unmapped", 6'h3c, 32'h0);
      wfor(1'b1, 200);
      rdc("irq_flag", A_IRQ_FLAG, 32'h1);
      bus(1'b1, A_IRQ_FLAG, 32'h1);
      $display("test reset done");
      state_req <= 3'h3;
      wfor(1'b0, 6000);
      repeat (3) @(posedge mclk);
      chk("pin target", 32'h28a, target_mv);
      bus(1'b1, A_TRACK_CFG, 32'h9);
      bus(1'b1, A_CTRL, 32'h1);
      wfor(1'b0, 3000);
      wfor(1'b0, 3000);
      t0 = $time;
      wfor(1'b0, 1000);
      chk("period", 640, 32'(($time - t0) / 20));
      repeat (3) @(posedge mclk);
      chk("reg target", 32'h1f4, target_mv);
      voc_mv <= 12'h7d0;
      bus(1'b1, A_TRACK_CFG, 32'h0);
      wfor(1'b0, 1000);
      wfor(1'b0, 1000);
      repeat (3) @(posedge mclk);
      chk("clamped target", 32'h5dc, target_mv);
      state_req <= 3'h4;
      k = n_strobe;
      repeat (1500) @(posedge mclk);
      chk("sleep strobes", 0, n_strobe - k);
      state_req <= 3'h3;
      k = n_therm;
      repeat (1000) @(posedge mclk);
      chk("thermal pulses", 10, n_therm - k);
      $display("test tracking done");
      rt(3'b000, 13'he74, 3'b010, 3'b111);
      rt(3'b100, 13'he74, 3'b100, 3'b111);
      rt(3'b000, 13'he74, 3'b100, 3'b111);
      rt(3'b010, 13'he74, 3'b010, 3'b111);
      rt(3'b000, 13'h10cc, 3'b000, 3'b111);
      rt(3'b001, 13'he74, 3'b000, 3'b111);
      bus(1'b1, A_CTRL, 32'h3);
      rt(3'b100, 13'he74, 3'b001, 3'b101);
      rt(3'b100, 13'hb54, 3'b000, 3'b101);
      rt(3'b000, 13'he74, 3'b000, 3'b100);
      $display("test routing done");
      bus(1'b1, A_IRQ_EN, 32'h3);
      bus(1'b1, A_MON_CFG, 32'h2);
      mon_next();
      t0 = $time;
      rdc("done flag", A_IRQ_FLAG, 32'h2);
      rdc("pulse count", A_MON_DATA, 32'h4);
      mon_next();
      chk("monitor cycle", 40, 32'(($time - t0) / 20));
      bus(1'b1, A_MON_CFG, 32'h10002);
      mon_next();
      mon_next();
      rdc("energy", A_MON_DATA, 32'hc);
      bus(1'b1, A_IRQ_EN, 32'h1);
      bus(1'b1, A_IRQ_FLAG, 32'h3);
      repeat (100) @(posedge mclk);
      chk("masked irq", 0, irq);
      rdc("done flag", A_IRQ_FLAG, 32'h2);
      $display("test monitor done");
      summarize();
   end
endmodule : tb_harvester_mppt_charge_control
bind hmc_charge_ctrl hmc_charge_ctrl_sva #(.THERM_CYCLES(THERM_CYCLES), .MS_TICK(MS_TICK)) u_sva (
   .mclk(mclk), .nrst(nrst), .state_req(state_req), .charge_inhibit(charge_inhibit),
   .at_overcharge_threshold(at_overcharge_threshold),
   .below_overdischarge_threshold(below_overdischarge_threshold),
   .source_isolation_switch(source_isolation_switch), .extract_enable(extract_enable),
   .sample_strobe(sample_strobe), .core_rail_switch(core_rail_switch),
   .battery_switch(battery_switch), .battery_to_core_switch(battery_to_core_switch),
   .thermal_sample(thermal_sample), .irq(irq));
